// >>> pkg/safety_fault_pkg.sv
package safety_fault_pkg;

    // Slot and unit counts
    localparam int NUM_SLOTS = 13;     // I/O slots, numbered 1 to 13
    localparam int BUS0_SLOTS = 7;     // Slots 1 to 7 sit on the first I/O bus
    localparam int NUM_BUS = 2;        // I/O buses
    localparam int NUM_CU = 2;         // Central units
    localparam int NUM_GROUPS = 4;     // Shutdown groups
    localparam int GROUP_MAX = 10;     // Largest group membership
    localparam int CH_W = 8;           // Input channels per input module

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_STRIDE = 4;

    // Register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] GROUP_OFF = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h20;
    localparam logic [7:0] CLEAR_OFF = 8'h24;
    localparam logic [7:0] IRQ_EN_OFF = 8'h28;
    localparam logic [7:0] OUT_SHUT_OFF = 8'h2C;
    localparam logic [7:0] IN_FORCED_OFF = 8'h30;
    localparam logic [7:0] SE_STATE_OFF = 8'h34;
    localparam logic [7:0] ERR_OFF = 8'h38;

    // Configuration fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int TOPO_LSB = 2;
    localparam int TOPO_W = 2;
    localparam int ESTOP_BIT = 4;
    localparam int GROUP_EN_BIT = 5;

    // Fault parameter codes
    localparam logic [1:0] MODE_DISPLAY = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_EOFF = 2'h2;

    // Topology codes
    localparam logic [1:0] TOPO_MONO = 2'h0;
    localparam logic [1:0] TOPO_RED_CU = 2'h1;
    localparam logic [1:0] TOPO_RED_BUS = 2'h2;

    // Status bit positions
    localparam int ST_OUT_SINGLE = 0;
    localparam int ST_OUT_DOUBLE = 1;
    localparam int ST_IO_BUS = 2;
    localparam int ST_CU = 3;
    localparam int ST_INPUT = 4;
    localparam int ST_ESTOP = 5;
    localparam int ST_W = 6;

    // Error report layout and codes
    localparam int ERR_SLOT_LSB = 0;
    localparam int ERR_SLOT_W = 4;
    localparam int ERR_CODE_LSB = 8;
    localparam int ERR_CODE_W = 4;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_DOUBLE = 4'h1;
    localparam logic [3:0] ERR_BUS0 = 4'h2;
    localparam logic [3:0] ERR_BUS1 = 4'h3;

endpackage

// >>> rtl/cu_fault_attrib.sv
`timescale 1ns/10ps
module cu_fault_attrib #(
    parameter int NUM_SLOTS = safety_fault_pkg::NUM_SLOTS,
    parameter int BUS0_SLOTS = safety_fault_pkg::BUS0_SLOTS
) (
    // Fault sources
    input wire logic [NUM_SLOTS-1:0] slot_fault_i,
    input wire logic [safety_fault_pkg::NUM_BUS-1:0] bus_fault_i,
    // Topology: redundant I/O bus
    input wire logic split_bus_i,
    // Central units to trip
    output logic [safety_fault_pkg::NUM_CU-1:0] cu_trip_o
);

    // Fault seen on each bus
    logic bus0_hit;
    logic bus1_hit;

    // Attribute each slot to its bus, then bus to central unit
    always_comb begin
        bus0_hit = bus_fault_i[0];
        bus1_hit = bus_fault_i[1];
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (i < BUS0_SLOTS) begin
                bus0_hit = bus0_hit | slot_fault_i[i];
            end else begin
                bus1_hit = bus1_hit | slot_fault_i[i];
            end
        end
        if (split_bus_i) begin
            cu_trip_o = {bus1_hit, bus0_hit};
        end else begin
            cu_trip_o = {2{bus0_hit | bus1_hit}};
        end
    end

endmodule

// >>> rtl/safety_fault_reaction_ctrl.sv
// Summary of operation
// - Faulty output module is de-energized alone
// - Group option de-energizes whole group, ten max
// - Emergency-off: output fault drops unit enable
// - Display-only: report slot code, enable stays
// - Normal: also drop enable on bus/double
// - Central unit fault always drops its enable
// - Input module fault forces inputs to zero
// - Input faults never drop unit enable
// - Emergency variable drops enable unconditionally
// - Display-only: output faults keep enable asserted
// - Shared bus: trip both central units
// - Redundant buses: trip related unit only
// - Slots 1-7 bus one, 8-13 bus two
// - Double fault: channel plus switch-off fault
`timescale 1ns/10ps
module safety_fault_reaction_ctrl #(
    parameter int NUM_SLOTS = safety_fault_pkg::NUM_SLOTS,
    parameter int NUM_GROUPS = safety_fault_pkg::NUM_GROUPS,
    parameter int CH_W = safety_fault_pkg::CH_W
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [safety_fault_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [safety_fault_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [safety_fault_pkg::DATA_W-1:0] reg_rdata_o,
    // Fault reports from modules and buses
    input wire logic [NUM_SLOTS-1:0] out_fault_i,
    input wire logic [NUM_SLOTS-1:0] switchoff_fault_i,
    input wire logic [NUM_SLOTS-1:0] in_fault_i,
    input wire logic [safety_fault_pkg::NUM_BUS-1:0] io_bus_fault_i,
    input wire logic [safety_fault_pkg::NUM_CU-1:0] cu_fault_i,
    // Input module data
    input wire logic [NUM_SLOTS*CH_W-1:0] in_data_i,
    output logic [NUM_SLOTS*CH_W-1:0] in_data_o,
    // Shutdown outputs
    output logic [NUM_SLOTS-1:0] out_enable_o,
    output logic [safety_fault_pkg::NUM_CU-1:0] safety_enable_signal_o,
    // Interrupt
    output logic irq_o
);

    localparam int ST_W = safety_fault_pkg::ST_W;
    localparam int NCU = safety_fault_pkg::NUM_CU;

    // Whole block state
    typedef struct packed {
        logic [1:0] mode;                              // Fault parameter
        logic [1:0] topo;                              // System topology
        logic estop;                                   // Emergency shutdown variable
        logic group_en;                                // Group shutdown configured
        logic [NUM_GROUPS-1:0][NUM_SLOTS-1:0] group;   // Group memberships
        logic [ST_W-1:0] status;                       // Sticky event bits
        logic [ST_W-1:0] irq_en;                       // Interrupt enables
        logic [NUM_SLOTS-1:0] out_shut;                // Latched module shutdowns
        logic [NUM_SLOTS-1:0] in_forced;               // Latched input forcing
        logic [NCU-1:0] se_trip;                       // Latched unit enable drops
        logic [3:0] err_slot;                          // Reported slot
        logic [3:0] err_code;                          // Reported error code
        logic [safety_fault_pkg::DATA_W-1:0] rdata;    // Read data
        logic [NUM_SLOTS*CH_W-1:0] in_data;            // Filtered input data
    } state_s;

    state_s st;       // Current state
    state_s next_st;  // Next state

    // Fault classification
    logic [NUM_SLOTS-1:0] double_fault;
    logic [NUM_SLOTS-1:0] single_fault;
    logic [NUM_SLOTS-1:0] group_shut;
    logic [NUM_SLOTS-1:0] attrib_slots;
    logic [safety_fault_pkg::NUM_BUS-1:0] attrib_bus;
    logic [NCU-1:0] attrib_trip;
    logic [ST_W-1:0] events;
    logic report_mode;

    // Group size limit is enforced on write, so a bad mask never takes effect
    // Count members of a group mask
    function automatic int count_ones(input logic [NUM_SLOTS-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            n = n + int'(v[i]);
        end
        return n;
    endfunction

    // Slot number (1-based) of the lowest set bit, zero if none
    function automatic logic [3:0] first_slot(input logic [NUM_SLOTS-1:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                s = 4'(i + 1);
            end
        end
        return s;
    endfunction

    // Classify channel faults
    always_comb begin
        double_fault = out_fault_i & switchoff_fault_i;
        single_fault = out_fault_i & ~double_fault;
    end

    // Membership only counts while group shutdown is configured
    // Expand group memberships of faulty modules
    always_comb begin
        group_shut = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (st.group_en && |(st.group[g] & out_fault_i)) begin
                group_shut = group_shut | st.group[g];
            end
        end
    end

    // Select faults that reach the central unit enables
    always_comb begin
        attrib_slots = '0;
        attrib_bus = '0;
        report_mode = 1'b0;
        unique case (st.mode)
            safety_fault_pkg::MODE_DISPLAY: begin
                // no enable drop
                // The module's own shutdown is trusted here
                report_mode = 1'b1;
            end
            safety_fault_pkg::MODE_EOFF: begin
                attrib_slots = out_fault_i;
                attrib_bus = io_bus_fault_i;
            end
            default: begin
                report_mode = 1'b1;
                attrib_slots = double_fault;
                attrib_bus = io_bus_fault_i;
            end
        endcase
    end

    // Topology codes other than the split one share a single bus
    // Map slot and bus faults onto central units
    cu_fault_attrib #(
        .NUM_SLOTS(NUM_SLOTS),
        .BUS0_SLOTS(safety_fault_pkg::BUS0_SLOTS)
    ) u_attrib (
        .slot_fault_i(attrib_slots),
        .bus_fault_i(attrib_bus),
        .split_bus_i(st.topo == safety_fault_pkg::TOPO_RED_BUS),
        .cu_trip_o(attrib_trip)
    );

    // The emergency bit keeps setting for as long as it is configured
    // Events that set sticky status
    always_comb begin
        events = '0;
        events[safety_fault_pkg::ST_OUT_SINGLE] = |single_fault;
        events[safety_fault_pkg::ST_OUT_DOUBLE] = |double_fault;
        events[safety_fault_pkg::ST_IO_BUS] = |io_bus_fault_i;
        events[safety_fault_pkg::ST_CU] = |cu_fault_i;
        events[safety_fault_pkg::ST_INPUT] = |in_fault_i;
        events[safety_fault_pkg::ST_ESTOP] = st.estop;
    end

    // Next state: registers, latches, read data
    always_comb begin
        next_st = st;
        next_st.rdata = '0;

        // Configuration write
        if (reg_wr_i && reg_addr_i == safety_fault_pkg::CFG_OFF) begin
            next_st.mode = reg_wdata_i[safety_fault_pkg::MODE_LSB +: safety_fault_pkg::MODE_W];
            next_st.topo = reg_wdata_i[safety_fault_pkg::TOPO_LSB +: safety_fault_pkg::TOPO_W];
            next_st.estop = reg_wdata_i[safety_fault_pkg::ESTOP_BIT];
            next_st.group_en = reg_wdata_i[safety_fault_pkg::GROUP_EN_BIT];
        end
        // Group mask writes; oversized groups are ignored
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (reg_wr_i && reg_addr_i == 8'(int'(safety_fault_pkg::GROUP_OFF) + g * safety_fault_pkg::REG_STRIDE)
                && count_ones(reg_wdata_i[NUM_SLOTS-1:0]) <= safety_fault_pkg::GROUP_MAX) begin
                next_st.group[g] = reg_wdata_i[NUM_SLOTS-1:0];
            end
        end
        // Interrupt enable write
        if (reg_wr_i && reg_addr_i == safety_fault_pkg::IRQ_EN_OFF) begin
            next_st.irq_en = reg_wdata_i[ST_W-1:0];
        end
        // Sticky status, a new event wins over the clear
        // Clearing while a fault persists leaves its bit set
        if (reg_wr_i && reg_addr_i == safety_fault_pkg::CLEAR_OFF) begin
            next_st.status = (st.status & ~reg_wdata_i[ST_W-1:0]) | events;
        end else begin
            next_st.status = st.status | events;
        end

        next_st.out_shut = st.out_shut | out_fault_i | group_shut;
        next_st.in_forced = st.in_forced | in_fault_i;
        next_st.se_trip = st.se_trip | attrib_trip | cu_fault_i | {NCU{st.estop}};

        // slot and code report
        // A double fault outranks a bus fault, and the lowest slot wins
        if (report_mode) begin
            if (|double_fault) begin
                next_st.err_slot = first_slot(double_fault);
                next_st.err_code = safety_fault_pkg::ERR_DOUBLE;
            end else if (io_bus_fault_i[0]) begin
                next_st.err_slot = 4'h0;
                next_st.err_code = safety_fault_pkg::ERR_BUS0;
            end else if (io_bus_fault_i[1]) begin
                next_st.err_slot = 4'h0;
                next_st.err_code = safety_fault_pkg::ERR_BUS1;
            end
        end

        // force inputs zero
        // The latch is read from next_st, so the first faulty sample is blanked
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (next_st.in_forced[s]) begin
                next_st.in_data[s*CH_W +: CH_W] = '0;
            end else begin
                next_st.in_data[s*CH_W +: CH_W] = in_data_i[s*CH_W +: CH_W];
            end
        end

        // Read decode, data stand in the following cycle
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                safety_fault_pkg::CFG_OFF: begin
                    next_st.rdata[safety_fault_pkg::MODE_LSB +: safety_fault_pkg::MODE_W] = st.mode;
                    next_st.rdata[safety_fault_pkg::TOPO_LSB +: safety_fault_pkg::TOPO_W] = st.topo;
                    next_st.rdata[safety_fault_pkg::ESTOP_BIT] = st.estop;
                    next_st.rdata[safety_fault_pkg::GROUP_EN_BIT] = st.group_en;
                end
                safety_fault_pkg::STATUS_OFF: begin
                    next_st.rdata[ST_W-1:0] = st.status;
                end
                safety_fault_pkg::IRQ_EN_OFF: begin
                    next_st.rdata[ST_W-1:0] = st.irq_en;
                end
                safety_fault_pkg::OUT_SHUT_OFF: begin
                    next_st.rdata[NUM_SLOTS-1:0] = st.out_shut;
                end
                safety_fault_pkg::IN_FORCED_OFF: begin
                    next_st.rdata[NUM_SLOTS-1:0] = st.in_forced;
                end
                safety_fault_pkg::SE_STATE_OFF: begin
                    next_st.rdata[NCU-1:0] = ~st.se_trip;
                end
                safety_fault_pkg::ERR_OFF: begin
                    next_st.rdata[safety_fault_pkg::ERR_SLOT_LSB +: safety_fault_pkg::ERR_SLOT_W] = st.err_slot;
                    next_st.rdata[safety_fault_pkg::ERR_CODE_LSB +: safety_fault_pkg::ERR_CODE_W] = st.err_code;
                end
                default: begin
                    // Group masks, then unmapped reads as zero
                    for (int g = 0; g < NUM_GROUPS; g++) begin
                        if (reg_addr_i == 8'(int'(safety_fault_pkg::GROUP_OFF) + g * safety_fault_pkg::REG_STRIDE)) begin
                            next_st.rdata[NUM_SLOTS-1:0] = st.group[g];
                        end
                    end
                end
            endcase
        end
    end

    // Only reset clears a latched shutdown or trip
    // State register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Enables are inverted latches, so reset leaves everything energized
    // Outputs from state
    always_comb begin
        reg_rdata_o = st.rdata;
        in_data_o = st.in_data;
        out_enable_o = ~st.out_shut;
        safety_enable_signal_o = ~st.se_trip;
        irq_o = |(st.status & st.irq_en);
    end

endmodule

// >>> verif/fault_reaction_assertions.sv
`timescale 1ns/10ps
module fault_reaction_checker #(
    parameter int NUM_SLOTS = safety_fault_pkg::NUM_SLOTS,
    parameter int CH_W = safety_fault_pkg::CH_W
) (
    // Clock, reset, writes
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Fault lines
    input wire logic [NUM_SLOTS-1:0] out_fault_i,
    input wire logic [NUM_SLOTS-1:0] switchoff_fault_i,
    input wire logic [NUM_SLOTS-1:0] in_fault_i,
    input wire logic [1:0] io_bus_fault_i,
    input wire logic [1:0] cu_fault_i,
    // Reactions
    input wire logic [NUM_SLOTS*CH_W-1:0] in_data_o,
    input wire logic [NUM_SLOTS-1:0] out_enable_o,
    input wire logic [1:0] safety_enable_signal_o
);
    logic [5:0] cfg; // Shadow of the configuration word
    logic [1:0] en; // Unit enables
    logic dbl; // Some module has a double fault
    logic calm; // No unit, bus or emergency cause
    assign en = safety_enable_signal_o;
    assign dbl = |(out_fault_i & switchoff_fault_i);
    assign calm = cu_fault_i == 2'h0 && io_bus_fault_i == 2'h0 && !cfg[4];
    // Follow configuration writes
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cfg <= 6'h00;
        end else if (reg_wr_i && reg_addr_i == safety_fault_pkg::CFG_OFF) begin
            cfg <= reg_wdata_i[5:0];
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_out_shut: assert property (out_fault_i[0] |=> !out_enable_o[0])
        else $error("faulty module still energized");
    chk_shut_hold: assert property (!out_enable_o[12] |=> !out_enable_o[12])
        else $error("module shutdown released");
    chk_trip_hold: assert property (!en[0] |=> !en[0])
        else $error("unit enable restored");
    chk_eoff_trip: assert property (cfg[3:0] == 4'h2 && out_fault_i != 0 |=> en == 2'h0)
        else $error("emergency-off kept enable");
    chk_display_keep: assert property (cfg[1:0] == 2'h0 && cu_fault_i == 2'h0 && !cfg[4] && &en |=> &en)
        else $error("display mode dropped enable");
    chk_double_trip: assert property (cfg[3:0] == 4'h5 && dbl |=> en == 2'h0)
        else $error("double fault kept enable");
    chk_single_keep: assert property (cfg[1:0] == 2'h1 && calm && !dbl && &en |=> &en)
        else $error("single fault dropped enable");
    chk_cu_trip: assert property (cu_fault_i[1] |=> !en[1])
        else $error("unit fault kept enable");
    chk_in_zero: assert property (in_fault_i[0] |=> in_data_o[CH_W-1:0] == '0)
        else $error("faulty input module not zeroed");
    chk_in_no_trip: assert property (cfg[1:0] == 2'h2 && calm && out_fault_i == 0 && &en |=> &en)
        else $error("input fault dropped enable");
    chk_estop_trip: assert property (cfg[4] |=> en == 2'h0)
        else $error("emergency variable kept enable");
    chk_split_trip: assert property (cfg[3:0] == 4'hA && calm && out_fault_i[12:7] == 0 && en[1]
        && out_fault_i[6:0] != 0 |=> en == 2'h2)
        else $error("wrong unit tripped");
    cov_estop: cover property (cfg[4] ##1 en == 2'h0);
    cov_group: cover property ($countones(~out_enable_o) > 1);
    cov_split: cover property (en == 2'h2);
endmodule

bind safety_fault_reaction_ctrl fault_reaction_checker #(.NUM_SLOTS(NUM_SLOTS), .CH_W(CH_W)) chk_inst (
    .core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .out_fault_i, .switchoff_fault_i,
    .in_fault_i, .io_bus_fault_i, .cu_fault_i, .in_data_o, .out_enable_o, .safety_enable_signal_o
);

// >>> verif/io_rack_model.sv
`timescale 1ns/10ps
module io_rack_model (
    // Clock and bench requests
    input wire logic core_clk_i,
    input wire logic [12:0] out_req_i,
    input wire logic [12:0] sw_req_i,
    input wire logic [12:0] in_req_i,
    input wire logic [1:0] bus_req_i,
    input wire logic [1:0] cu_req_i,
    input wire logic [103:0] seed_i,
    // Lines toward the controller
    output logic [12:0] out_fault_o = 13'h0,
    output logic [12:0] switchoff_fault_o = 13'h0,
    output logic [12:0] in_fault_o = 13'h0,
    output logic [1:0] io_bus_fault_o = 2'h0,
    output logic [1:0] cu_fault_o = 2'h0,
    output logic [103:0] in_data_o = 104'h0
);
    logic [7:0] tick = 8'h00; // Refresh count
    // Faults are held levels; input data change every cycle
    always @(posedge core_clk_i) begin
        {out_fault_o, switchoff_fault_o, in_fault_o, io_bus_fault_o, cu_fault_o} <=
            {out_req_i, sw_req_i, in_req_i, bus_req_i, cu_req_i};
        tick <= tick + 8'h01;
        in_data_o <= seed_i ^ {13{tick}};
    end
endmodule

// >>> verif/safety_fault_reaction_ctrl_test.sv
`timescale 1ns/10ps
module safety_fault_reaction_ctrl_test;
    // Register port
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic irq_o;
    // Rack requests, lines and group masks
    logic [12:0] oq = 13'h0, sq = 13'h0, iq = 13'h0, of, sf, inf, oe, gm [4];
    logic [1:0] bq = 2'h0, cq = 2'h0, bf, cf, se;
    logic [103:0] seed = 104'h0, di, dq, prev;
    logic [31:0] rng = 32'hBCA89AA6, d;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    safety_fault_reaction_ctrl dut (
        .core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .out_fault_i(of), .switchoff_fault_i(sf), .in_fault_i(inf), .io_bus_fault_i(bf), .cu_fault_i(cf),
        .in_data_i(di), .in_data_o(dq), .out_enable_o(oe), .safety_enable_signal_o(se), .irq_o
    );
    io_rack_model rack (
        .core_clk_i, .out_req_i(oq), .sw_req_i(sq), .in_req_i(iq), .bus_req_i(bq), .cu_req_i(cq),
        .seed_i(seed), .out_fault_o(of), .switchoff_fault_o(sf), .in_fault_o(inf), .io_bus_fault_o(bf),
        .cu_fault_o(cf), .in_data_o(di)
    );
    initial forever #2.5 core_clk_i = ~core_clk_i;
    // Last input word and hang guard
    always @(posedge core_clk_i) begin
        prev <= di;
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [103:0] s, input logic [103:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus write and read cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    function automatic logic [31:0] nx();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Expected unit enables from mode, topology and faults
    function automatic logic [1:0] exp_se(input logic [5:0] c, input logic [12:0] o, s, input logic [1:0] b, u);
        logic [12:0] src;
        logic bt;
        logic [1:0] t;
        bt = c[1:0] != 2'h0;
        src = c[1:0] == 2'h2 ? o : (bt ? o & s : 13'h0);
        if (c[3:2] == 2'h2)
            t = {|src[12:7] | (bt & b[1]), |src[6:0] | (bt & b[0])};
        else
            t = {2{|src | (bt & |b)}};
        return ~(t | u | {2{c[4]}});
    endfunction
    function automatic logic [12:0] exp_oe(input logic ge, input logic [12:0] o);
        logic [12:0] sh;
        sh = o;
        // Masks with more members than a group may hold are refused on write
        for (int g = 0; g < 4; g++)
            if (ge && $countones(gm[g]) <= safety_fault_pkg::GROUP_MAX && |(o & gm[g])) sh = sh | gm[g];
        return ~sh;
    endfunction
    // Error report: double fault first, then first bus, then second bus
    function automatic logic [31:0] exp_err(input logic [5:0] c, input logic [12:0] x, input logic [1:0] b);
        logic [31:0] e;
        e = 32'h0;
        if (c[1:0] != 2'h2) begin
            if (b[1]) e = 32'h300;
            if (b[0]) e = 32'h200;
            for (int k = 12; k >= 0; k--)
                if (x[k]) e = 32'h100 + 32'(k + 1);
        end
        return e;
    endfunction
    // One case from a fresh reset
    task automatic run_case(input logic [5:0] c, input logic [12:0] o, s, i, input logic [1:0] b, u);
        logic [103:0] m;
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        {oq, sq, iq, bq, cq} <= 43'h0;
        seed <= 104'({nx(), nx(), nx(), nx()});
        // Two reset edges, so stale fault lines are gone before release
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int g = 0; g < 4; g++)
            wr(8'h10 + 8'(4 * g), 32'(gm[g]));
        // mode stands for the application's safety level
        wr(8'h00, 32'(c));
        {oq, sq, iq, bq, cq} <= {o, s, i, b, u};
        repeat (4) @(posedge core_clk_i);
        #1;
        for (int k = 0; k < 104; k++)
            m[k] = !i[k / 8];
        check(104'(oe), 104'(exp_oe(c[5], o)));
        check(104'(se), 104'(exp_se(c, o, s, b, u)));
        check(dq, prev & m);
        rd(8'h20, d);
        check(104'(d[5:0]), 104'({c[4], |i, |u, |b, |(o & s), |(o & ~s)}));
        rd(8'h38, d);
        check(104'(d), 104'(exp_err(c, o & s, b)));
        $display("case %h done", c);
    endtask
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        // Oversized group, unmapped read, interrupt
        wr(8'h10, 32'h03FF);
        wr(8'h10, 32'h07FF);
        rd(8'h10, d);
        check(104'(d), 104'h3FF);
        rd(8'h3C, d);
        check(104'(d), 104'h0);
        wr(8'h28, 32'h08);
        cq <= 2'h1;
        repeat (3) @(posedge core_clk_i);
        #1 check(104'({irq_o, se}), 104'h6);
        wr(8'h28, 32'h0);
        #1 check(104'(irq_o), 104'h0);
        cq <= 2'h0;
        wr(8'h28, 32'h08);
        wr(8'h24, 32'h08);
        wr(8'h20, 32'h3F);
        #1 check(104'({irq_o, se}), 104'h2);
        rd(8'h20, d);
        check(104'(d), 104'h0);
        $display("register test done");
        // Corner cases
        gm = '{13'h03FF, 13'h0, 13'h1C00, 13'h0};
        run_case(6'h21, 13'h0001, 13'h0, 13'h0, 2'h0, 2'h0);
        run_case(6'h10, 13'h0, 13'h0, 13'h0, 2'h0, 2'h0);
        run_case(6'h02, 13'h0, 13'h0, 13'h1FFF, 2'h0, 2'h0);
        run_case(6'h0A, 13'h0040, 13'h0, 13'h0, 2'h0, 2'h0);
        run_case(6'h0A, 13'h0080, 13'h0, 13'h0, 2'h0, 2'h0);
        run_case(6'h05, 13'h0, 13'h0, 13'h0, 2'h1, 2'h0);
        run_case(6'h00, 13'h0100, 13'h0100, 13'h0, 2'h2, 2'h0);
        run_case(6'h0B, 13'h0012, 13'h0010, 13'h0, 2'h0, 2'h0);
        // Random cases
        repeat (150) begin
            for (int g = 0; g < 4; g++)
                gm[g] = 13'(nx() & nx());
            d = nx();
            run_case(d[5:0], 13'(nx() & nx()), 13'(nx()), 13'(nx() & nx() & nx()), 2'(nx() & nx()),
                2'(nx() & nx() & nx()));
        end
        wrap_up();
    end
endmodule
